// [hdl/serializer_cfg_pkg.sv]
// Constants, field layout and mode encodings for the parallel capture block
package serializer_cfg_pkg;
  localparam int DATA_W     = 24;
  localparam int CTRL_W     = 3;
  localparam int WORD_W     = DATA_W + CTRL_W;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W     = 8;
  // Bit positions inside the synchronised pin vector
  localparam int P_DATA = 0;
  localparam int P_CTRL = 24;
  localparam int P_PCLK = 27;
  localparam int P_EDGE = 28;
  localparam int P_CFG  = 29;
  localparam int P_ST   = 31;
  localparam int P_EMPH = 32;
  localparam int P_RSV  = 33;
  localparam int P_PDN  = 36;
  localparam int SYN_W  = 37;
  // Register map
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam int C_EDGE_OVR  = 0;
  localparam int C_EDGE_RISE = 1;
  localparam int C_EMPH_OVR  = 2;
  localparam int C_EMPH_ON   = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int S_RISE = 0;
  localparam int S_CFG  = 1;
  localparam int S_ST   = 3;
  localparam int S_EMPH = 4;
  localparam int S_PD   = 5;
  localparam int S_RSV  = 6;
  localparam int S_OVF  = 9;
  localparam int S_LVL  = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Filter: a new control level is forwarded on the capture after this many differing ones
  localparam logic [1:0] FILT_LAST = 2'h2;
  localparam logic [1:0] CFG_RAW   = 2'h0;
  localparam logic [1:0] CFG_FILT  = 2'h1;
  localparam logic [1:0] CFG_LEG_A = 2'h2;
  localparam logic [1:0] CFG_LEG_B = 2'h3;
  typedef enum logic [3:0] {
    MODE_RAW   = 4'h1,
    MODE_FILT  = 4'h2,
    MODE_LEG_A = 4'h4,
    MODE_LEG_B = 4'h8
  } link_mode_t;
endpackage : serializer_cfg_pkg

// [hdl/parallel_capture.sv]
// Parallel pixel capture, strap decode, control filter, FIFO and register slave
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps

module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, nxt_wr;
  logic [AW-1:0]    rd_ff, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem_ff[rd_ff];
  assign level     = cnt_ff;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update; depth must be a power of two for wrap
  always_comb begin
    nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      nxt_wr  = '0;
      nxt_rd  = '0;
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; only written entries are ever read
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule : word_fifo

module parallel_capture
  import serializer_cfg_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [DATA_W-1:0] parallel_data_in,
  input  wire logic              data_enable_in,
  input  wire logic              hsync_in,
  input  wire logic              vsync_in,
  input  wire logic              parallel_clock_in,
  input  wire logic              capture_edge_select,
  input  wire logic [1:0]        config_strap,
  input  wire logic              selftest_enable,
  input  wire logic              emphasis_control,
  input  wire logic [2:0]        reserved_straps,
  input  wire logic              power_down_n,
  output logic [WORD_W-1:0]      word_data,
  output logic                   word_valid,
  input  wire logic              word_ready,
  output link_mode_t             link_mode,
  output logic                   selftest_active,
  output logic                   emphasis_enable,
  output logic                   serial_out_p,
  output logic                   serial_out_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic link_mode_t decode_mode(input logic [1:0] cfg);
    unique case (cfg)
      CFG_RAW:   decode_mode = MODE_RAW;
      CFG_FILT:  decode_mode = MODE_FILT;
      CFG_LEG_A: decode_mode = MODE_LEG_A;
      CFG_LEG_B: decode_mode = MODE_LEG_B;
    endcase
  endfunction : decode_mode

  // Pin synchroniser: three stages, a bit moves once stages two and three agree
  logic [SYN_W-1:0] pin_raw;
  logic [SYN_W-1:0] s1_ff, s2_ff, s3_ff, q_ff, nxt_q;
  assign pin_raw = {power_down_n, reserved_straps, emphasis_control, selftest_enable,
                    config_strap, capture_edge_select, parallel_clock_in,
                    vsync_in, hsync_in, data_enable_in, parallel_data_in};

  always_comb begin
    nxt_q = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & q_ff);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff  <= '0;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  // Pin-derived levels and clock edge events
  logic             running, pclk_rise, pclk_fall, rise_eff, cap_ev;
  logic [CTRL_W-1:0] ctrl_s;
  logic [3:0]       ctrl_ff, nxt_ctrl;
  assign running   = q_ff[P_PDN];
  assign pclk_rise = nxt_q[P_PCLK] && !q_ff[P_PCLK];
  assign pclk_fall = !nxt_q[P_PCLK] && q_ff[P_PCLK];
  assign ctrl_s    = q_ff[P_CTRL +: CTRL_W];
  // Register override wins over the strap when enabled
  assign rise_eff  = ctrl_ff[C_EDGE_OVR] ? ctrl_ff[C_EDGE_RISE] : q_ff[P_EDGE];
  assign cap_ev    = running && (rise_eff ? pclk_rise : pclk_fall);

  // Capture, control filter and mode outputs
  logic [CTRL_W-1:0] flt_ff, nxt_flt;
  logic [1:0]        run_ff [CTRL_W];
  logic [1:0]        nxt_run [CTRL_W];
  logic              push_ff, nxt_push, ovf_ff, nxt_ovf, fifo_in_ready, ovf_clr;
  logic [WORD_W-1:0] push_data_ff, nxt_push_data;
  link_mode_t        mode_ff, nxt_mode;
  logic              st_ff, nxt_st, emph_ff, nxt_emph, sp_ff, sn_ff;
  logic              filt_on;
  assign filt_on = mode_ff == MODE_FILT;

  genvar gi;
  generate
    for (gi = 0; gi < CTRL_W; gi++) begin : g_filt
      // A new level must persist across three captures before it is forwarded
      always_comb begin
        nxt_flt[gi] = flt_ff[gi];
        nxt_run[gi] = run_ff[gi];
        if (cap_ev) begin
          if (!filt_on || ctrl_s[gi] == flt_ff[gi]) begin
            nxt_flt[gi] = ctrl_s[gi];
            nxt_run[gi] = '0;
          end else if (run_ff[gi] == FILT_LAST) begin
            nxt_flt[gi] = ctrl_s[gi];
            nxt_run[gi] = '0;
          end else begin
            nxt_run[gi] = run_ff[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_push      = push_ff && !fifo_in_ready;
    nxt_push_data = push_data_ff;
    nxt_ovf       = ovf_ff && !ovf_clr;
    // A held word stalls capture; a newer capture is lost and flagged
    if (cap_ev) begin
      if (nxt_push) begin
        nxt_ovf = 1'b1;
      end else begin
        nxt_push      = 1'b1;
        nxt_push_data = {nxt_flt, q_ff[P_DATA +: DATA_W]};
      end
    end
    nxt_mode = decode_mode(q_ff[P_CFG +: 2]);
    nxt_st   = q_ff[P_ST];
    // Pulled-up pin floats high, which leaves emphasis off
    nxt_emph = ctrl_ff[C_EMPH_OVR] ? ctrl_ff[C_EMPH_ON] : !q_ff[P_EMPH];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !running) begin
      flt_ff       <= '0;
      push_ff      <= 1'b0;
      push_data_ff <= '0;
      mode_ff      <= MODE_RAW;
      st_ff        <= 1'b0;
      emph_ff      <= 1'b0;
      sp_ff        <= 1'b1;
      sn_ff        <= 1'b1;
      ovf_ff       <= !aresetn ? 1'b0 : nxt_ovf;
      for (int i = 0; i < CTRL_W; i++) run_ff[i] <= '0;
    end else begin
      flt_ff       <= nxt_flt;
      push_ff      <= nxt_push;
      push_data_ff <= nxt_push_data;
      mode_ff      <= nxt_mode;
      st_ff        <= nxt_st;
      emph_ff      <= nxt_emph;
      sp_ff        <= 1'b1; // Idle differential level; encoder sits downstream
      sn_ff        <= 1'b0;
      ovf_ff       <= nxt_ovf;
      for (int i = 0; i < CTRL_W; i++) run_ff[i] <= nxt_run[i];
    end
  end

  // Word FIFO and registered output stage
  logic              fifo_out_valid, fifo_pop, ov_ff, nxt_ov;
  logic [WORD_W-1:0] fifo_out_data, od_ff, nxt_od;
  logic [4:0]        fifo_level;
  assign fifo_pop = fifo_out_valid && (!ov_ff || word_ready);

  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (!running),
    .in_valid  (push_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_ff),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  always_comb begin
    nxt_ov = ov_ff && !word_ready;
    nxt_od = od_ff;
    if (fifo_pop) begin
      nxt_ov = 1'b1;
      nxt_od = fifo_out_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !running) begin
      ov_ff <= 1'b0;
      od_ff <= '0;
    end else begin
      ov_ff <= nxt_ov;
      od_ff <= nxt_od;
    end
  end

  // AXI4-Lite slave: address and data taken in either order, one of each at a time
  logic              awr_ff, nxt_awr, wr_ff, nxt_wr, aw_h_ff, nxt_aw_h, w_h_ff, nxt_w_h;
  logic              bv_ff, nxt_bv, arr_ff, nxt_arr, rv_ff, nxt_rv, wr_go;
  logic [ADDR_W-1:0] awa_ff, nxt_awa;
  logic [31:0]       wd_ff, nxt_wd, rd_ff, nxt_rd, status;
  logic [3:0]        ws_ff, nxt_ws;
  logic [1:0]        br_ff, nxt_br, rr_ff, nxt_rr;

  assign status = {11'h000, fifo_level, 6'h00, ovf_ff, q_ff[P_RSV +: 3], !running,
                   emph_ff, st_ff, q_ff[P_CFG +: 2], rise_eff};
  assign wr_go   = aw_h_ff && w_h_ff && !bv_ff;
  assign ovf_clr = wr_go && awa_ff == ADDR_STATUS && ws_ff[S_OVF/8] && wd_ff[S_OVF];

  always_comb begin
    nxt_aw_h = aw_h_ff || (s_axi_awvalid && awr_ff);
    nxt_w_h  = w_h_ff || (s_axi_wvalid && wr_ff);
    nxt_awa  = (s_axi_awvalid && awr_ff) ? s_axi_awaddr : awa_ff;
    nxt_wd   = (s_axi_wvalid && wr_ff) ? s_axi_wdata : wd_ff;
    nxt_ws   = (s_axi_wvalid && wr_ff) ? s_axi_wstrb : ws_ff;
    nxt_bv   = bv_ff && !s_axi_bready;
    nxt_br   = br_ff;
    nxt_ctrl = ctrl_ff;
    if (wr_go) begin
      nxt_aw_h = 1'b0;
      nxt_w_h  = 1'b0;
      nxt_bv   = 1'b1;
      nxt_br   = (awa_ff == ADDR_CTRL || awa_ff == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
      if (awa_ff == ADDR_CTRL && ws_ff[0]) begin
        nxt_ctrl = wd_ff[3:0];
      end
    end
    nxt_awr = !nxt_aw_h;
    nxt_wr  = !nxt_w_h;
    // Read side: one outstanding read, data registered with the response
    nxt_rv = rv_ff && !s_axi_rready;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_axi_arvalid && arr_ff) begin
      nxt_rv = 1'b1;
      nxt_rr = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CTRL:   nxt_rd = {28'h000_0000, ctrl_ff};
        ADDR_STATUS: nxt_rd = status;
        default: begin
          nxt_rd = 32'h0000_0000;
          nxt_rr = RESP_SLVERR;
        end
      endcase
    end
    nxt_arr = !nxt_rv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_ff <= 1'b0;
      wr_ff  <= 1'b0;
      aw_h_ff <= 1'b0;
      w_h_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff  <= '0;
      ws_ff  <= '0;
      bv_ff  <= 1'b0;
      br_ff  <= RESP_OKAY;
      arr_ff <= 1'b0;
      rv_ff  <= 1'b0;
      rd_ff  <= '0;
      rr_ff  <= RESP_OKAY;
    end else begin
      awr_ff <= nxt_awr;
      wr_ff  <= nxt_wr;
      aw_h_ff <= nxt_aw_h;
      w_h_ff <= nxt_w_h;
      awa_ff <= nxt_awa;
      wd_ff  <= nxt_wd;
      ws_ff  <= nxt_ws;
      bv_ff  <= nxt_bv;
      br_ff  <= nxt_br;
      arr_ff <= nxt_arr;
      rv_ff  <= nxt_rv;
      rd_ff  <= nxt_rd;
      rr_ff  <= nxt_rr;
    end
  end

  // Control register is wiped by power-down as well as by reset
  always_ff @(posedge aclk) begin
    if (!aresetn || !running) begin
      ctrl_ff <= CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign s_axi_awready   = awr_ff;
  assign s_axi_wready    = wr_ff;
  assign s_axi_bvalid    = bv_ff;
  assign s_axi_bresp     = br_ff;
  assign s_axi_arready   = arr_ff;
  assign s_axi_rvalid    = rv_ff;
  assign s_axi_rdata     = rd_ff;
  assign s_axi_rresp     = rr_ff;
  assign word_valid      = ov_ff;
  assign word_data       = od_ff;
  assign link_mode       = mode_ff;
  assign selftest_active = st_ff;
  assign emphasis_enable = emph_ff;
  assign serial_out_p    = sp_ff;
  assign serial_out_n    = sn_ff;

  a_rise_capture: assert property ((running && rise_eff && pclk_rise
    && !(push_ff && !fifo_in_ready))
    |=> push_ff && push_data_ff[DATA_W-1:0] == $past(q_ff[DATA_W-1:0]))
    else $error("rising edge capture missed");
  a_fall_capture: assert property ((running && !rise_eff && !push_ff && pclk_rise && !pclk_fall)
    |=> !push_ff)
    else $error("captured on wrong edge");
  a_filter_mode: assert property ((running && q_ff[P_CFG +: 2] == CFG_FILT) ##1 running
    |-> mode_ff == MODE_FILT)
    else $error("filter mode not decoded");
  a_legacy_mode: assert property ((running && q_ff[P_CFG +: 2] == CFG_LEG_B) ##1 running
    |-> mode_ff == MODE_LEG_B && mode_ff != MODE_LEG_A)
    else $error("legacy mode not decoded");
  a_selftest_follow: assert property (running && $past(running) |->
    selftest_active == $past(q_ff[P_ST]))
    else $error("self-test does not follow strap");
  a_edge_override: assert property (ctrl_ff[C_EDGE_OVR] |-> rise_eff == ctrl_ff[C_EDGE_RISE])
    else $error("edge override ignored");
  a_emph_float: assert property ((running && !ctrl_ff[C_EMPH_OVR] && q_ff[P_EMPH]) ##1 running
    |-> !emphasis_enable)
    else $error("emphasis on with floating pin");
  a_powerdown_out: assert property (!running |=> serial_out_p && serial_out_n
    && ctrl_ff == CTRL_RST && !word_valid)
    else $error("power-down state wrong");
  a_filter_short: assert property ((running && filt_on && cap_ev && ctrl_s[0] != flt_ff[0]
    && run_ff[0] != FILT_LAST) |=> flt_ff[0] == $past(flt_ff[0]))
    else $error("short control pulse forwarded");
endmodule : parallel_capture

// [testbench/video_source.sv]
// Behavioural parallel video source that drives the capture pins
`timescale 1ns/1ps
module video_source (
  input  wire logic        aclk,
  input  wire logic        run,
  input  wire logic [23:0] rnd,
  input  wire logic [2:0]  ctrl_lvl,
  output logic [23:0]      pix,
  output logic [2:0]       ctrl,
  output logic             pclk
);
  logic [3:0]  cnt_ff;
  logic [26:0] rise_q[$];
  logic [26:0] fall_q[$];
  initial begin
    cnt_ff = 4'h0;
    pix    = 24'h00_0000;
    ctrl   = 3'h0;
    pclk   = 1'b0;
  end
  // Twelve aclk per parallel clock, so each phase spans six; clock rests low
  always @(posedge aclk) begin
    if (run || cnt_ff != 4'h0) begin
      cnt_ff <= (cnt_ff == 4'hb) ? 4'h0 : cnt_ff + 4'h1;
      pclk   <= (cnt_ff >= 4'h5) && (cnt_ff != 4'hb);
      if (cnt_ff == 4'h2) begin
        pix  <= rnd;
        ctrl <= ctrl_lvl; // Once per clock: widths in whole clocks
      end
      if (cnt_ff == 4'h8) begin
        pix <= rnd; // A second word, so the two edges see different data
      end
      if (cnt_ff == 4'h5) begin
        rise_q.push_back({ctrl, pix});
      end
      if (cnt_ff == 4'hb) begin
        fall_q.push_back({ctrl, pix});
      end
    end else begin
      pix <= ~pix; // Clock at rest: data is meaningless, never a stale copy
    end
  end
endmodule : video_source

// [testbench/tb_top.sv]
// Self-checking bench for the parallel capture block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_top
  import serializer_cfg_pkg::*;
;
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic              s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb = '0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp, c, rdy_mode = 0;
  logic              capture_edge_select = 1, selftest_enable = 0, emphasis_control = 1;
  logic              power_down_n = 1, word_ready = 1, src_run = 0;
  logic [1:0]        config_strap = 0;
  logic [2:0]        reserved_straps = 3'h0; // Held low throughout
  wire  [23:0]       parallel_data_in;
  wire               data_enable_in, hsync_in, vsync_in, parallel_clock_in;
  logic [WORD_W-1:0] word_data;
  logic              word_valid, selftest_active, emphasis_enable, serial_out_p, serial_out_n;
  link_mode_t        link_mode;
  logic [23:0]       rnd = '0;
  logic [2:0]        ctrl_lvl = '0, filt_ff = '0;
  int                seed = 34845, error_cnt = 0, total_checks = 0, fcnt[3];
  bit                chk_en = 0, exp_rise = 1, filt_on = 0;

  parallel_capture dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .parallel_data_in, .data_enable_in, .hsync_in, .vsync_in,
    .parallel_clock_in, .capture_edge_select, .config_strap, .selftest_enable,
    .emphasis_control, .reserved_straps, .power_down_n, .word_data, .word_valid, .word_ready,
    .link_mode, .selftest_active, .emphasis_enable, .serial_out_p, .serial_out_n);
  video_source src (.aclk, .run(src_run), .rnd, .ctrl_lvl, .pix(parallel_data_in),
    .ctrl({vsync_in, hsync_in, data_enable_in}), .pclk(parallel_clock_in));

  initial begin
    forever #50 aclk = ~aclk;
  end
  // Random pixels and random back-pressure on the word output
  always @(posedge aclk) begin
    rnd        <= 24'($random(seed));
    word_ready <= (rdy_mode == 2'h0) ? 1'b1 : (rdy_mode == 2'h1) ? 1'($random(seed)) : 1'b0;
  end
  // Expected control level: a change lands on its third consecutive capture
  function automatic logic [2:0] filt_step(input logic [2:0] raw);
    for (int i = 0; i < 3; i++) begin
      if (!filt_on || raw[i] == filt_ff[i]) begin
        filt_ff[i] = raw[i];
        fcnt[i] = 0;
      end else begin
        fcnt[i]++;
        if (fcnt[i] == 3) begin
          filt_ff[i] = raw[i];
          fcnt[i] = 0;
        end
      end
    end
    return filt_ff;
  endfunction : filt_step
  function automatic int q_left();
    return exp_rise ? src.rise_q.size() : src.fall_q.size();
  endfunction : q_left
  // Each accepted word against what stood on the pins at the chosen edge
  always @(posedge aclk) begin : mon
    logic [26:0] exp_w;
    if (chk_en && word_valid && word_ready) begin
      exp_w = 'x;
      if (q_left() > 0) exp_w = exp_rise ? src.rise_q.pop_front() : src.fall_q.pop_front();
      exp_w[26:24] = filt_step(exp_w[26:24]);
      `CHK("word", exp_w, word_data)
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bit awd, wd;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    awd = 0;
    wd = 0;
    forever begin
      @(posedge aclk);
      if (!awd && s_axi_awready) begin
        awd = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ard;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    ard = 0;
    forever begin
      @(posedge aclk);
      if (!ard && s_axi_arready) begin
        ard = 1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Run n parallel clocks; control mask m is high for len clocks from clock p
  task automatic stream(input int n, input bit rise, input int p, input int len,
                        input logic [2:0] m);
    src.rise_q.delete();
    src.fall_q.delete();
    filt_ff = '0;
    fcnt = '{0, 0, 0};
    @(posedge aclk);
    exp_rise <= rise;
    src_run  <= 1'b1;
    for (int k = 0; k < n; k++) begin
      ctrl_lvl <= (k >= p && k < p + len) ? m : 3'h0;
      repeat (12) @(posedge aclk);
    end
    src_run <= 1'b0;
    repeat (30) @(posedge aclk); // Margin for the pin synchronisers
    if (chk_en) begin
      for (int w = 0; w < 600 && q_left() > 0; w++) @(posedge aclk);
      `CHK("words left", 0, q_left())
    end
  endtask : stream
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(ADDR_CTRL, rd, rsp);
    `CHK("ctrl reset", CTRL_RST, rd[3:0])
    `CHK("serial idle", 2'b10, {serial_out_p, serial_out_n})
    axi_wr(8'h10, 32'h0000_000f, 4'hf, RESP_SLVERR);
    axi_rd(8'h08, rd, rsp);
    `CHK("unmapped rresp", RESP_SLVERR, rsp)
    // Every strap code, self-test and emphasis pin level
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      config_strap     <= c;
      selftest_enable  <= c[0];
      emphasis_control <= c[1];
      repeat (8) @(posedge aclk);
      `CHK("mode", link_mode_t'(4'h1 << i), link_mode)
      `CHK("selftest", c[0], selftest_active)
      `CHK("emphasis", ~c[1], emphasis_enable)
      axi_rd(ADDR_STATUS, rd, rsp);
      `CHK("status", {3'h0, 1'b0, ~c[1], c[0], c}, rd[8:1])
    end
    // Floating pin, register override, then a write with its byte lane off
    emphasis_control <= 1'b1;
    axi_wr(ADDR_CTRL, 32'h0000_000c, 4'h1, RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK("emph ovr on", 1'b1, emphasis_enable)
    axi_wr(ADDR_CTRL, 32'h0000_0004, 4'h1, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h0000_000c, 4'h2, RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK("emph ovr off", 1'b0, emphasis_enable)
    config_strap    <= 2'h0;
    selftest_enable <= 1'b0;
    // Strap and override combinations choose the capture edge
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      capture_edge_select <= c[0];
      axi_wr(ADDR_CTRL, {30'h0, c[1] & ~c[0], c[1]}, 4'h1, RESP_OKAY);
      repeat (8) @(posedge aclk);
      axi_rd(ADDR_STATUS, rd, rsp);
      `CHK("edge", c[0] ^ c[1], rd[0])
      chk_en   <= 1'b1;
      rdy_mode <= 2'h1;
      stream(20, c[0] ^ c[1], 0, 0, 3'h0);
    end
    axi_wr(ADDR_CTRL, 32'h0000_0000, 4'h1, RESP_OKAY);
    // Short enable pulse, then a long sync pulse; vertical sync never moves
    for (int i = 0; i < 2; i++) begin
      config_strap <= 2'(i);
      filt_on = (i == 1);
      repeat (8) @(posedge aclk);
      stream(140, 1'b1, 3, 1, 3'h1);
      stream(140, 1'b1, 3, 4, 3'h2);
    end
    // Output stalled until the buffer refuses
    config_strap <= 2'h0;
    filt_on = 0;
    chk_en   <= 1'b0;
    rdy_mode <= 2'h2;
    stream(30, 1'b1, 0, 0, 3'h0);
    axi_rd(ADDR_STATUS, rd, rsp);
    `CHK("overflow", 6'h30, {rd[9], rd[20:16]})
    axi_wr(ADDR_STATUS, 32'h0000_0200, 4'h2, RESP_OKAY);
    rdy_mode <= 2'h0;
    repeat (60) @(posedge aclk);
    axi_rd(ADDR_STATUS, rd, rsp);
    `CHK("drained", 6'h00, {rd[9], rd[20:16]})
    // Power-down clears the control register and parks both serial outputs high
    axi_wr(ADDR_CTRL, 32'h0000_000f, 4'h1, RESP_OKAY);
    axi_rd(ADDR_CTRL, rd, rsp);
    `CHK("ctrl rw", 4'hf, rd[3:0])
    power_down_n <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK("serial pd", 2'b11, {serial_out_p, serial_out_n})
    axi_rd(ADDR_STATUS, rd, rsp);
    `CHK("pd status", 1'b1, rd[5])
    power_down_n <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(ADDR_CTRL, rd, rsp);
    `CHK("ctrl after pd", CTRL_RST, rd[3:0])
    `CHK("serial up", 2'b10, {serial_out_p, serial_out_n})
    summarize();
  end
endmodule : tb_top
